// ==== adc_ctrl_pkg.sv ====
// Types shared by the converter control block
package adc_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_STOP    = 4'b0001,
    ST_STANDBY = 4'b0010,
    ST_STAB    = 4'b0100,
    ST_CONVERT = 4'b1000
  } conv_state_t;
endpackage

// ==== adc_ctrl_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define OFS_MODE_PRIMARY    4'h0
`define OFS_MODE_SECONDARY  4'h1
`define OFS_MODE_TERTIARY   4'h2
`define OFS_CHANNEL_SELECT  4'h3
`define OFS_RESULT_LOW      4'h4
`define OFS_RESULT_HIGH     4'h5
`define OFS_UPPER_LIMIT     4'h6
`define OFS_LOWER_LIMIT     4'h7
`define OFS_PORT_CONFIG     4'h8
`define OFS_STATUS          4'h9

`define BIT_POWER_ENABLE    0
`define BIT_CONV_RUN        7
`define BIT_ONE_SHOT        0
`define BIT_TRIG_SOURCE     1
`define BIT_WAKEUP_CONV     2
`define BIT_RANGE_CHECK     3

`define RST_MODE_PRIMARY    8'h00
`define RST_MODE_SECONDARY  8'h00
`define RST_MODE_TERTIARY   8'h00
`define RST_CHANNEL_SELECT  8'h00
`define RST_UPPER_LIMIT     8'hFF
`define RST_LOWER_LIMIT     8'h00
`define RST_PORT_CONFIG     8'h00
`define RST_RESULT          10'h000

`define CLK_PERIOD_NS       10
`define STAB_WAIT_NS        1000
`define STAB_WAIT_CYC       ((`STAB_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC            34
`define CNT_W               8
`define CNT_ONE             8'h01
`define CNT_ZERO            8'h00

`endif

// ==== adc_hw_trigger_wait_cpu_free_conversion_state_ctrl.sv ====
// Converter control: trigger-wait modes, CPU-free conversion state, range-gated result store
// Contract
// (RULE1) Power enable on enters trigger standby only
// (RULE2) Trigger in standby starts conversion, sets run
// (RULE3) Conversion end stores result, raises done irq
// (RULE4) Sequential mode restarts conversion without trigger
// (RULE5) Trigger during conversion aborts and restarts
// (RULE6) Channel write during conversion restarts new channel
// (RULE7) Writing run one while converting restarts
// (RULE8) Clearing run aborts to standby, converter stopped
// (RULE9) Power enable zero ignores triggers entirely
// (RULE10) One-shot end clears run, converter stops
// (RULE11) Withheld irq also suppresses result update
// (RULE12) STOP-mode trigger converts; one-shot only there
// (RULE13) Software arms low-power only on fast oscillator
// (RULE14) Software arms wakeup bit, then power enable
// (RULE15) Low-power trigger requests clock, waits, converts
// (RULE16) Software programs secondary mode to permitted values
// (RULE17) Triggers are calendar or interval timer irq
// (RULE18) In-range low-power result raises irq, exits state
// (RULE19) Software clears wakeup bit after irq
// (RULE20) No irq in low-power drops clock request
// (RULE21) Clearing run in low-power drops clock request
// (RULE22) Result read wins over coincident result write
// (RULE23) Config write at end skips store and irq
// (RULE24) Power enable bit 0, run bit 7
// (RULE25) Triggers are single-cycle synchronous events
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "adc_ctrl_regs.svh"
`default_nettype none

module adc_hw_trigger_wait_cpu_free_conversion_state_ctrl (
  input  wire logic       clk_sys,              // System clock, 100 MHz
  input  wire logic       rst_n,                // Asynchronous reset, active low
  input  wire logic [3:0] reg_addr,             // Register address
  input  wire logic [7:0] reg_wdata,            // Write data
  input  wire logic       reg_wr,               // Write strobe
  input  wire logic       reg_rd,               // Read strobe
  output logic      [7:0] reg_rdata,            // Read data, cycle after strobe
  input  wire logic       calendar_timer_irq,   // Calendar timer trigger pulse
  input  wire logic       interval_timer_irq,   // Interval timer trigger pulse
  input  wire logic       stop_mode,            // CPU is in STOP mode
  input  wire logic [9:0] sample_data,          // Analog core result at conversion end
  output logic            conversion_done_irq,  // One-cycle done pulse
  output logic            clock_request,        // Fast oscillator request
  output logic            sample_start,         // One-cycle pulse: core restarts sampling
  output logic      [4:0] sample_channel        // Channel given to the analog core
);

  logic [7:0]               mode_primary_r;
  logic [7:0]               mode_secondary_r;
  logic [7:0]               mode_tertiary_r;
  logic [7:0]               channel_select_r;
  logic [7:0]               upper_limit_r;
  logic [7:0]               lower_limit_r;
  logic [7:0]               port_config_r;
  logic [9:0]               result_r;
  logic [9:0]               pend_result_r;
  logic                     pend_valid_r;
  adc_ctrl_pkg::conv_state_t state_r;
  adc_ctrl_pkg::conv_state_t state_nxt;
  logic [`CNT_W-1:0]        cnt_r;
  logic [`CNT_W-1:0]        cnt_nxt;
  logic                     run_nxt;
  logic                     restart;
  logic                     conv_end;
  logic                     store_ok;
  logic                     cfg_write;
  logic                     res_read;
  logic                     trigger;
  logic                     in_range;
  logic                     low_power;

  // Write and read decode, shared by several concerns
  function automatic logic hit(input logic strobe, input logic [3:0] a, input logic [3:0] ofs);
    hit = strobe && (a == ofs);
  endfunction

  // Triggers arrive already synchronous as one-cycle pulses; source chosen by secondary mode
  assign trigger = mode_secondary_r[`BIT_TRIG_SOURCE] ? interval_timer_irq : calendar_timer_irq; // RULE17 RULE25
  assign low_power = mode_tertiary_r[`BIT_WAKEUP_CONV] && stop_mode;
  assign cfg_write = hit(reg_wr, reg_addr, `OFS_MODE_PRIMARY) || hit(reg_wr, reg_addr, `OFS_CHANNEL_SELECT)
                     || hit(reg_wr, reg_addr, `OFS_PORT_CONFIG);
  assign res_read  = hit(reg_rd, reg_addr, `OFS_RESULT_LOW) || hit(reg_rd, reg_addr, `OFS_RESULT_HIGH);
  assign conv_end  = (state_r == adc_ctrl_pkg::ST_CONVERT) && (cnt_r == `CNT_ONE);

  // Range check compares the top eight result bits with the limits
  assign in_range = !mode_tertiary_r[`BIT_RANGE_CHECK]
                    ? (sample_data[9:2] >= lower_limit_r) && (sample_data[9:2] <= upper_limit_r)
                    : (sample_data[9:2] < lower_limit_r) || (sample_data[9:2] > upper_limit_r);
  assign store_ok = conv_end && in_range && !cfg_write; // RULE11 RULE23

  // Restart causes while converting: trigger, channel write, run rewritten to one
  assign restart = (state_r == adc_ctrl_pkg::ST_CONVERT) && (trigger // RULE5
                   || hit(reg_wr, reg_addr, `OFS_CHANNEL_SELECT) // RULE6
                   || (hit(reg_wr, reg_addr, `OFS_MODE_PRIMARY) && reg_wdata[`BIT_CONV_RUN]
                       && reg_wdata[`BIT_POWER_ENABLE])); // RULE7

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    run_nxt   = mode_primary_r[`BIT_CONV_RUN];
    if (hit(reg_wr, reg_addr, `OFS_MODE_PRIMARY)) begin
      run_nxt = reg_wdata[`BIT_CONV_RUN] && reg_wdata[`BIT_POWER_ENABLE];
    end
    unique case (state_r)
      adc_ctrl_pkg::ST_STOP: begin
        if (mode_primary_r[`BIT_POWER_ENABLE]) begin
          state_nxt = adc_ctrl_pkg::ST_STANDBY; // RULE1
        end
      end
      adc_ctrl_pkg::ST_STANDBY: begin
        if (!mode_primary_r[`BIT_POWER_ENABLE]) begin
          state_nxt = adc_ctrl_pkg::ST_STOP; // RULE9
        end else if (trigger) begin
          run_nxt = 1'b1; // RULE2
          if (low_power) begin
            state_nxt = adc_ctrl_pkg::ST_STAB; // RULE15
            cnt_nxt   = `CNT_W'(`STAB_WAIT_CYC);
          end else begin
            state_nxt = adc_ctrl_pkg::ST_CONVERT; // RULE2
            cnt_nxt   = `CNT_W'(`CONV_CYC);
          end
        end
      end
      adc_ctrl_pkg::ST_STAB: begin
        if (!run_nxt || !mode_primary_r[`BIT_POWER_ENABLE]) begin
          state_nxt = adc_ctrl_pkg::ST_STANDBY; // RULE21
        end else if (cnt_r == `CNT_ONE) begin
          state_nxt = adc_ctrl_pkg::ST_CONVERT; // RULE12 RULE15
          cnt_nxt   = `CNT_W'(`CONV_CYC);
        end else begin
          cnt_nxt = cnt_r - `CNT_ONE;
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        if (!run_nxt || !mode_primary_r[`BIT_POWER_ENABLE]) begin
          state_nxt = adc_ctrl_pkg::ST_STANDBY; // RULE8
          cnt_nxt   = `CNT_ZERO;
        end else if (restart) begin
          cnt_nxt = `CNT_W'(`CONV_CYC);
        end else if (conv_end) begin
          if (mode_secondary_r[`BIT_ONE_SHOT] || low_power) begin
            state_nxt = adc_ctrl_pkg::ST_STANDBY; // RULE10 RULE12 RULE20
            run_nxt   = 1'b0; // RULE10
            cnt_nxt   = `CNT_ZERO;
          end else begin
            cnt_nxt = `CNT_W'(`CONV_CYC); // RULE4
          end
        end else begin
          cnt_nxt = cnt_r - `CNT_ONE;
        end
      end
    endcase
  end

  // Sequencer state and countdown
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= adc_ctrl_pkg::ST_STOP;
      cnt_r   <= `CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Primary mode: power enable written by software, run also set and cleared by hardware
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_primary_r <= `RST_MODE_PRIMARY;
    end else begin
      if (hit(reg_wr, reg_addr, `OFS_MODE_PRIMARY)) begin
        mode_primary_r <= reg_wdata; // RULE24
      end
      mode_primary_r[`BIT_CONV_RUN] <= run_nxt; // RULE2 RULE10
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_secondary_r <= `RST_MODE_SECONDARY;
      mode_tertiary_r  <= `RST_MODE_TERTIARY;
      channel_select_r <= `RST_CHANNEL_SELECT;
      upper_limit_r    <= `RST_UPPER_LIMIT;
      lower_limit_r    <= `RST_LOWER_LIMIT;
      port_config_r    <= `RST_PORT_CONFIG;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_MODE_SECONDARY) begin
        mode_secondary_r <= reg_wdata;
      end
      if (reg_addr == `OFS_MODE_TERTIARY) begin
        mode_tertiary_r <= reg_wdata; // RULE19
      end
      if (reg_addr == `OFS_CHANNEL_SELECT) begin
        channel_select_r <= reg_wdata;
      end
      if (reg_addr == `OFS_UPPER_LIMIT) begin
        upper_limit_r <= reg_wdata;
      end
      if (reg_addr == `OFS_LOWER_LIMIT) begin
        lower_limit_r <= reg_wdata;
      end
      if (reg_addr == `OFS_PORT_CONFIG) begin
        port_config_r <= reg_wdata;
      end
    end
  end

  // Result store; a coincident read sees the old value, the new one lands a cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_r      <= `RST_RESULT;
      pend_result_r <= `RST_RESULT;
      pend_valid_r  <= 1'b0;
    end else begin
      pend_valid_r <= store_ok && res_read; // RULE22
      if (store_ok) begin
        pend_result_r <= sample_data;
      end
      if (store_ok && !res_read) begin
        result_r <= sample_data; // RULE3
      end else if (pend_valid_r) begin
        result_r <= pend_result_r; // RULE22
      end
    end
  end

  // Done pulse and clock request; request holds through stabilisation and conversion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_irq <= 1'b0;
      clock_request       <= 1'b0;
    end else begin
      conversion_done_irq <= store_ok; // RULE3 RULE18
      clock_request       <= !low_power || (state_nxt == adc_ctrl_pkg::ST_STAB)
                             || (state_nxt == adc_ctrl_pkg::ST_CONVERT); // RULE20 RULE21
    end
  end

  // Core start pulse and channel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample_start   <= 1'b0;
      sample_channel <= 5'h00;
    end else begin
      sample_start   <= (state_nxt == adc_ctrl_pkg::ST_CONVERT) && (cnt_nxt == `CNT_W'(`CONV_CYC));
      sample_channel <= hit(reg_wr, reg_addr, `OFS_CHANNEL_SELECT) ? reg_wdata[4:0] : channel_select_r[4:0];
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_MODE_PRIMARY:   reg_rdata <= mode_primary_r;
        `OFS_MODE_SECONDARY: reg_rdata <= mode_secondary_r;
        `OFS_MODE_TERTIARY:  reg_rdata <= mode_tertiary_r;
        `OFS_CHANNEL_SELECT: reg_rdata <= channel_select_r;
        `OFS_RESULT_LOW:     reg_rdata <= result_r[7:0];
        `OFS_RESULT_HIGH:    reg_rdata <= {6'h00, result_r[9:8]};
        `OFS_UPPER_LIMIT:    reg_rdata <= upper_limit_r;
        `OFS_LOWER_LIMIT:    reg_rdata <= lower_limit_r;
        `OFS_PORT_CONFIG:    reg_rdata <= port_config_r;
        `OFS_STATUS:         reg_rdata <= {4'h0, state_r};
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks
  a_power_off_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == adc_ctrl_pkg::ST_STANDBY && !mode_primary_r[`BIT_POWER_ENABLE])
    |=> state_r != adc_ctrl_pkg::ST_CONVERT) else $error("conversion started with power off"); // RULE9
  a_enable_standby: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == adc_ctrl_pkg::ST_STOP && mode_primary_r[`BIT_POWER_ENABLE])
    |=> state_r == adc_ctrl_pkg::ST_STANDBY) else $error("power enable did not reach standby"); // RULE1
  a_trigger_starts: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == adc_ctrl_pkg::ST_STANDBY && mode_primary_r[`BIT_POWER_ENABLE] && trigger && !low_power
     && !reg_wr) |=> (state_r == adc_ctrl_pkg::ST_CONVERT) && mode_primary_r[`BIT_CONV_RUN])
    else $error("trigger did not start conversion"); // RULE2
  a_done_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (store_ok && !res_read) |=> conversion_done_irq && result_r == $past(sample_data))
    else $error("result not stored with done pulse"); // RULE3
  a_seq_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (conv_end && !mode_secondary_r[`BIT_ONE_SHOT] && !low_power && run_nxt && !restart)
    |=> state_r == adc_ctrl_pkg::ST_CONVERT && cnt_r == `CNT_W'(`CONV_CYC))
    else $error("sequential mode did not restart"); // RULE4
  a_abort_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (restart && run_nxt) |=> cnt_r == `CNT_W'(`CONV_CYC) ##1 !conversion_done_irq)
    else $error("abort did not restart conversion"); // RULE5 RULE6 RULE7
  a_run_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == adc_ctrl_pkg::ST_CONVERT && !run_nxt)
    |=> state_r == adc_ctrl_pkg::ST_STANDBY ##1 !conversion_done_irq)
    else $error("run clear did not abort"); // RULE8
  a_one_shot_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (conv_end && mode_secondary_r[`BIT_ONE_SHOT] && run_nxt && !restart)
    |=> !mode_primary_r[`BIT_CONV_RUN] && state_r == adc_ctrl_pkg::ST_STANDBY)
    else $error("one-shot end did not clear run"); // RULE10
  a_withheld_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (conv_end && (!in_range || cfg_write) && !pend_valid_r) |=> !conversion_done_irq && $stable(result_r))
    else $error("withheld result was stored"); // RULE11 RULE23
  a_read_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (store_ok && res_read) |=> $stable(result_r) ##1 result_r == $past(sample_data, 2))
    else $error("read did not win over result write"); // RULE22
  a_lp_clock_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (low_power && state_nxt == adc_ctrl_pkg::ST_STANDBY) |=> !clock_request)
    else $error("clock request held after low-power end"); // RULE20 RULE21
  a_lp_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == adc_ctrl_pkg::ST_STANDBY && state_nxt == adc_ctrl_pkg::ST_STAB)
    |=> clock_request && state_r == adc_ctrl_pkg::ST_STAB)
    else $error("low-power trigger skipped stabilisation"); // RULE15 RULE12

  // Run can never stand without power, except when a standby trigger meets a write that clears power enable
  a_run_needs_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mode_primary_r[`BIT_POWER_ENABLE] |-> !mode_primary_r[`BIT_CONV_RUN])
    else $error("run bit set with power off"); // RULE9 RULE24

  // The core must see the channel that software last selected at every start
  a_start_channel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sample_start |-> sample_channel == channel_select_r[4:0])
    else $error("start with stale channel"); // RULE2 RULE6

  // Outside the CPU-free state the fast oscillator stays requested
  a_normal_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !low_power |=> clock_request)
    else $error("clock request low in normal mode"); // RULE18

  // Done is a pulse; a conversion is never shorter than one cycle
  a_done_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    conversion_done_irq |=> !conversion_done_irq)
    else $error("done pulse longer than one cycle"); // RULE3

  // Read data stand only in the cycle after a read strobe, else zero
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle"); // RULE22

  // A stabilisation wait always ends in a conversion or an abort to standby
  a_stab_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == adc_ctrl_pkg::ST_STAB && state_nxt != adc_ctrl_pkg::ST_STAB)
    |=> state_r == adc_ctrl_pkg::ST_CONVERT || state_r == adc_ctrl_pkg::ST_STANDBY)
    else $error("stabilisation left to a wrong state"); // RULE15 RULE21

endmodule

`default_nettype wire

// ==== adc_hw_trigger_wait_cpu_free_conversion_state_ctrl_tb_top.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "adc_ctrl_regs.svh"
`default_nettype none
module adc_hw_trigger_wait_cpu_free_conversion_state_ctrl_tb_top;
  logic       clk_sys, rst_n, reg_wr, reg_rd, stop_mode, fire, src_sel;
  logic       cal_irq, itv_irq, done, clk_req, s_start;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [9:0] level, data;
  logic [4:0] s_chan, ch;
  int         errors, n_compared, cyc, n, exp_res;

  trig_src_model src_u (.fire(fire), .src_sel(src_sel), .level(level), .cal_irq(cal_irq),
    .itv_irq(itv_irq), .data(data));
  adc_hw_trigger_wait_cpu_free_conversion_state_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .calendar_timer_irq(cal_irq), .interval_timer_irq(itv_irq), .stop_mode(stop_mode),
    .sample_data(data), .conversion_done_irq(done), .clock_request(clk_req),
    .sample_start(s_start), .sample_channel(s_chan));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the roughly one thousand cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Bus cycles: one strobe cycle, read data taken in the cycle after
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic trig();
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask

  // Looks first in the current cycle (k=1), then after each edge; lim+1 when never seen.
  // Starts launched by the edge that ended the last bus call stand only in that cycle.
  task automatic wait_sig(input bit w, input int lim, output int k);
    for (k = 1; k <= lim; k++) begin
      #1;
      if ((w ? done : s_start) === 1'b1) break;
      @(posedge clk_sys);
    end
  endtask

  // One triggered conversion followed to its end against the model result
  task automatic conv(input logic [9:0] v, input bit irq, input bit lp);
    level <= v;
    trig();
    wait_sig(0, 110, n);
    chk("start delay", 16'h1, lp ? (n >= 100 && n <= 103) : n == 1);
    rd(`OFS_MODE_PRIMARY, rv);
    chk("run set", 16'h1, rv[`BIT_CONV_RUN]);
    wait_sig(1, 33, n);
    chk("done delay", irq ? 33 : 34, n);
    if (irq) exp_res = v;
    rd(`OFS_RESULT_LOW, rv);
    chk("result lo", exp_res[7:0], rv);
    rd(`OFS_RESULT_HIGH, rv);
    chk("result hi", exp_res[9:8], rv);
  endtask

  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, stop_mode, fire, src_sel} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    level = '0;
    {errors, n_compared, cyc, exp_res} = '0;
    void'($urandom(32'hC857));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(4'hC, 8'h5A);
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], rv);
      chk("reset reg", a == 6 ? 8'hFF : (a == 9 ? 8'h01 : 8'h00), rv);
    end
    $display("test reset done");
    wr(`OFS_MODE_SECONDARY, 8'h01);
    wr(`OFS_MODE_PRIMARY, 8'h80);
    trig();
    wait_sig(0, 40, n);
    chk("start power off", 41, n);
    wr(`OFS_MODE_PRIMARY, 8'h01);
    wait_sig(0, 5, n);
    chk("start on power", 6, n);
    rd(`OFS_STATUS, rv);
    chk("standby", 8'h02, rv);
    $display("test power done");
    ch = 5'($urandom_range(31, 0));
    wr(`OFS_CHANNEL_SELECT, {3'h0, ch});
    conv(10'($urandom_range(1023, 0)), 1'b1, 1'b0);
    chk("channel", ch, s_chan);
    rd(`OFS_MODE_PRIMARY, rv);
    chk("one-shot run", 8'h01, rv);
    $display("test one-shot done");
    src_sel <= 1'b1;
    wr(`OFS_MODE_SECONDARY, 8'h02);
    conv(10'($urandom_range(1023, 0)), 1'b1, 1'b0);
    wait_sig(1, 40, n);
    chk("next done", 31, n);
    for (int k = 0; k < 3; k++) begin
      repeat (10) @(posedge clk_sys);
      if (k == 0) trig();
      else if (k == 1) wr(`OFS_CHANNEL_SELECT, 8'h07);
      else wr(`OFS_MODE_PRIMARY, 8'h81);
      wait_sig(0, 1, n);
      chk("restart", 1, n);
      wait_sig(1, 35, n);
      chk("restart len", 35, n);
    end
    chk("new channel", 5'h07, s_chan);
    repeat (10) @(posedge clk_sys);
    wr(`OFS_MODE_PRIMARY, 8'h01);
    wait_sig(1, 40, n);
    chk("no done after clear", 41, n);
    rd(`OFS_STATUS, rv);
    chk("back to standby", 8'h02, rv);
    $display("test sequential done");
    for (int k = 0; k < 2; k++) begin
      level <= ~exp_res[9:0];
      trig();
      wait_sig(0, 1, n);
      repeat (32) @(posedge clk_sys);
      if (k == 0) wr(`OFS_PORT_CONFIG, 8'h00);
      else rd(`OFS_RESULT_LOW, rv);
      #1;
      if (k == 0) chk("irq on clash", 0, done);
      else chk("read first", exp_res[7:0], rv);
      if (k == 1) exp_res = ~exp_res[9:0];
      rd(`OFS_RESULT_LOW, rv);
      chk("result after clash", exp_res[7:0], rv);
      wr(`OFS_MODE_PRIMARY, 8'h01);
    end
    wr(`OFS_UPPER_LIMIT, 8'h10);
    conv(10'h3FF, 1'b0, 1'b0);
    wr(`OFS_MODE_PRIMARY, 8'h01);
    wr(`OFS_MODE_TERTIARY, 8'h08);
    conv(10'h3FF, 1'b1, 1'b0);
    wr(`OFS_MODE_PRIMARY, 8'h00);
    $display("test range done");
    wr(`OFS_MODE_SECONDARY, 8'hE3);
    wr(`OFS_MODE_TERTIARY, 8'h04);
    stop_mode <= 1'b1;
    wr(`OFS_MODE_PRIMARY, 8'h01);
    conv(10'h3FF, 1'b0, 1'b1);
    chk("request dropped", 0, clk_req);
    trig();
    wait_sig(0, 110, n);
    chk("request resumed", 1, clk_req);
    wr(`OFS_MODE_PRIMARY, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("request after clear", 0, clk_req);
    wr(`OFS_UPPER_LIMIT, 8'hFF);
    conv(10'($urandom_range(1023, 0)), 1'b1, 1'b1);
    stop_mode <= 1'b0;
    wr(`OFS_MODE_TERTIARY, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("normal request", 1, clk_req);
    $display("test low power done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== trig_src_model.sv ====
// Timer trigger sources and analog core stand-in facing the converter control
`timescale 1ns/100ps
`default_nettype none
module trig_src_model (
  input  wire logic       fire,     // Bench asks for one trigger cycle
  input  wire logic       src_sel,  // 0 calendar timer, 1 interval timer
  input  wire logic [9:0] level,    // Analog level to report
  output logic            cal_irq,  // Calendar timer pulse
  output logic            itv_irq,  // Interval timer pulse
  output logic      [9:0] data      // Core result at conversion end
);
  // Fire is held one cycle only, so each pulse is one clock wide
  assign cal_irq = fire & ~src_sel;
  assign itv_irq = fire & src_sel;
  // Level is set by the bench well before any conversion end
  assign data    = level;
endmodule
`default_nettype wire
